// ### logic/capture_unit_b_c_config.sv
/*
 * Configuration registers and two capture units (B and C) with sticky event
 * status, mask and one level interrupt.
 * Assumes a plain register port from a parameter master and a bank of
 * internal signals indexed by source code, all synchronous to mclk.
 */
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
// Function
// - Unit B edge selection register, values 0 to 3.
// - Unit C has its own independent edge selection register, 0 to 3.
// - Single trigger mode latches on first qualifying edge, then ignores edges.
// - Continuous mode latches on every qualifying edge, overwriting the value.
// - Edge code 0 off, 1 rising, 2 falling, 3 both edges.
// - After a single capture, no capture until the master resets the unit.
module capture_unit_b_c_config #(
	parameter int SIG_W = 32,
	parameter int NSRC = 128
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_b,
	// Register port.
	input wire logic [3:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] regRdata,
	// Capture triggers.
	input wire logic trigB,
	input wire logic trigC,
	// Internal signal bank, one word per source code.
	input wire logic [NSRC*SIG_W-1:0] srcBank,
	// Interrupt.
	output logic irq
);
	logic [15:0] bEdgeReg;
	logic [15:0] bTrigReg;
	logic [15:0] bSrcLoReg;
	logic [15:0] bSrcHiReg;
	logic [15:0] cEdgeReg;
	logic [15:0] cTrigReg;
	logic [15:0] cSrcLoReg;
	logic [15:0] cSrcHiReg;
	logic [1:0] statusReg;
	logic [1:0] maskReg;
	logic [15:0] rdataReg;
	logic irqReg;
	logic [1:0] status_next;
	logic [15:0] rdata_next;

	// Next values of the configuration words and the mask.
	logic [15:0] bEdge_next;
	logic [15:0] bTrig_next;
	logic [15:0] bSrcLo_next;
	logic [15:0] bSrcHi_next;
	logic [15:0] cEdge_next;
	logic [15:0] cTrig_next;
	logic [15:0] cSrcLo_next;
	logic [15:0] cSrcHi_next;
	logic [1:0] mask_next;

	// Interrupt.
	logic irq_next;

	// Write decode, one strobe per writable register index.
	logic wrBEdge;
	logic wrBTrig;
	logic wrBLo;
	logic wrBHi;
	logic wrCEdge;
	logic wrCTrig;
	logic wrCLo;
	logic wrCHi;
	logic wrCtrl;
	logic wrStatus;
	logic wrMask;

	// Unit control and events.
	logic [1:0] rearm;
	logic [1:0] capEvt;
	logic [1:0] armed;
	logic [1:0] clrMask;

	// Source selection and captured words.
	logic [SIG_W-1:0] srcB;
	logic [SIG_W-1:0] srcC;
	logic [SIG_W-1:0] heldB;
	logic [SIG_W-1:0] heldC;
	logic [SIG_W-1:0] loWordB;
	logic [SIG_W-1:0] hiWordB;
	logic [SIG_W-1:0] loWordC;
	logic [SIG_W-1:0] hiWordC;
	logic [15:0] srcBLoHalf;
	logic [SIG_W-17:0] srcBHiHalf;
	logic [15:0] srcCLoHalf;
	logic [SIG_W-17:0] srcCHiHalf;

	// Read decode, one select per register index.
	logic rdSelBEdge;
	logic rdSelBTrig;
	logic rdSelBLo;
	logic rdSelBHi;
	logic rdSelCEdge;
	logic rdSelCTrig;
	logic rdSelCLo;
	logic rdSelCHi;
	logic rdSelCtrl;
	logic rdSelStatus;
	logic rdSelMask;
	logic rdSelBValLo;
	logic rdSelBValHi;
	logic rdSelCValLo;
	logic rdSelCValHi;
	logic [15:0] ctrlView;
	logic [15:0] statusView;
	logic [15:0] maskView;
	logic [15:0] rdMux;

	// Unmapped indices raise no strobe, so such writes are simply dropped.
	assign wrBEdge = regWr & (regAddr == capture_pkg::B_EDGE_ADDR);
	assign wrBTrig = regWr & (regAddr == capture_pkg::B_TRIG_ADDR);
	assign wrBLo = regWr & (regAddr == capture_pkg::B_SRCLO_ADDR);
	assign wrBHi = regWr & (regAddr == capture_pkg::B_SRCHI_ADDR);
	assign wrCEdge = regWr & (regAddr == capture_pkg::C_EDGE_ADDR);
	assign wrCTrig = regWr & (regAddr == capture_pkg::C_TRIG_ADDR);
	assign wrCLo = regWr & (regAddr == capture_pkg::C_SRCLO_ADDR);
	assign wrCHi = regWr & (regAddr == capture_pkg::C_SRCHI_ADDR);
	assign wrCtrl = regWr & (regAddr == capture_pkg::CTRL_ADDR);
	assign wrStatus = regWr & (regAddr == capture_pkg::STATUS_ADDR);
	assign wrMask = regWr & (regAddr == capture_pkg::MASK_ADDR);

	// Writing a one to a control bit rearms that unit; it is a pulse, not stored.
	assign rearm = wrCtrl ? regWdata[1:0] : capture_pkg::EVT_RESET;

	// The low code picks the lower 16 bits of the captured word, the high code
	// the upper 16 bits, so two codes together name one signal. Out-of-range
	// codes read as zero rather than aliasing onto another source.
	function automatic logic [SIG_W-1:0] pick(input logic [15:0] code,
		input logic [NSRC*SIG_W-1:0] bank);
		logic [SIG_W-1:0] w;
		w = '0;
		if (int'(code) < NSRC) begin
			w = bank[int'(code)*SIG_W +: SIG_W];
		end
		return w;
	endfunction

	assign loWordB = pick(bSrcLoReg, srcBank);
	assign hiWordB = pick(bSrcHiReg, srcBank);
	assign loWordC = pick(cSrcLoReg, srcBank);
	assign hiWordC = pick(cSrcHiReg, srcBank);
	// The high code supplies the upper bits and the low code the lower sixteen.
	// A code outside the bank gives zero for its half only.
	assign srcBLoHalf = loWordB[15:0];
	assign srcBHiHalf = hiWordB[SIG_W-1:16];
	assign srcCLoHalf = loWordC[15:0];
	assign srcCHiHalf = hiWordC[SIG_W-1:16];
	assign srcB = {srcBHiHalf, srcBLoHalf};
	assign srcC = {srcCHiHalf, srcCLoHalf};

	// Both units share the bank but nothing else; a write to one unit's words
	// never disturbs the other unit's capture state.
	capture_unit #(.SIG_W(SIG_W)) unitB (
		.mclk(mclk),
		.rst_b(rst_b),
		.edgeSel(bEdgeReg[1:0]),
		.trigType(bTrigReg[0]),
		.rearm(rearm[capture_pkg::BIT_B]),
		.trigIn(trigB),
		.srcVal(srcB),
		.heldVal(heldB),
		.captured(capEvt[capture_pkg::BIT_B]),
		.armed(armed[capture_pkg::BIT_B])
	);

	capture_unit #(.SIG_W(SIG_W)) unitC (
		.mclk(mclk),
		.rst_b(rst_b),
		.edgeSel(cEdgeReg[1:0]),
		.trigType(cTrigReg[0]),
		.rearm(rearm[capture_pkg::BIT_C]),
		.trigIn(trigC),
		.srcVal(srcC),
		.heldVal(heldC),
		.captured(capEvt[capture_pkg::BIT_C]),
		.armed(armed[capture_pkg::BIT_C])
	);

	// Write-one-to-clear mask; only a status write may clear bits.
	assign clrMask = wrStatus ? regWdata[1:0] : capture_pkg::EVT_RESET;
	// A capture in the same cycle as a write-one-to-clear keeps its bit set,
	// since dropping it would lose an event that software has not yet seen.
	assign status_next = (statusReg & ~clrMask) | capEvt;

	// Read decode: an index outside the map selects nothing.
	assign rdSelBEdge = (regAddr == capture_pkg::B_EDGE_ADDR);
	assign rdSelBTrig = (regAddr == capture_pkg::B_TRIG_ADDR);
	assign rdSelBLo = (regAddr == capture_pkg::B_SRCLO_ADDR);
	assign rdSelBHi = (regAddr == capture_pkg::B_SRCHI_ADDR);
	assign rdSelCEdge = (regAddr == capture_pkg::C_EDGE_ADDR);
	assign rdSelCTrig = (regAddr == capture_pkg::C_TRIG_ADDR);
	assign rdSelCLo = (regAddr == capture_pkg::C_SRCLO_ADDR);
	assign rdSelCHi = (regAddr == capture_pkg::C_SRCHI_ADDR);
	assign rdSelCtrl = (regAddr == capture_pkg::CTRL_ADDR);
	assign rdSelStatus = (regAddr == capture_pkg::STATUS_ADDR);
	assign rdSelMask = (regAddr == capture_pkg::MASK_ADDR);
	assign rdSelBValLo = (regAddr == capture_pkg::B_VALLO_ADDR);
	assign rdSelBValHi = (regAddr == capture_pkg::B_VALHI_ADDR);
	assign rdSelCValLo = (regAddr == capture_pkg::C_VALLO_ADDR);
	assign rdSelCValHi = (regAddr == capture_pkg::C_VALHI_ADDR);

	// The two-bit registers read with the rest of the word at zero.
	assign ctrlView = {14'h0000, armed};
	assign statusView = {14'h0000, statusReg};
	assign maskView = {14'h0000, maskReg};

	// Selects are mutually exclusive, so an AND-OR tree replaces a priority chain
	// and an unmapped index falls out as zero without a separate default term.
	assign rdMux = ({16{rdSelBEdge}} & bEdgeReg) |
		({16{rdSelBTrig}} & bTrigReg) |
		({16{rdSelBLo}} & bSrcLoReg) |
		({16{rdSelBHi}} & bSrcHiReg) |
		({16{rdSelCEdge}} & cEdgeReg) |
		({16{rdSelCTrig}} & cTrigReg) |
		({16{rdSelCLo}} & cSrcLoReg) |
		({16{rdSelCHi}} & cSrcHiReg) |
		({16{rdSelCtrl}} & ctrlView) |
		({16{rdSelStatus}} & statusView) |
		({16{rdSelMask}} & maskView) |
		({16{rdSelBValLo}} & heldB[15:0]) |
		({16{rdSelBValHi}} & heldB[SIG_W-1:16]) |
		({16{rdSelCValLo}} & heldC[15:0]) |
		({16{rdSelCValHi}} & heldC[SIG_W-1:16]);
	assign rdata_next = regRd ? rdMux : capture_pkg::ZERO16;

	// Only the low field bits are stored; a wider code is clipped, so an
	// edge code above 3 or trigger above 1 cannot reach an illegal state.
	assign bEdge_next = wrBEdge ? {14'h0000, regWdata[1:0]} : bEdgeReg;
	assign bTrig_next = wrBTrig ? {15'h0000, regWdata[0]} : bTrigReg;
	assign bSrcLo_next = wrBLo ? regWdata : bSrcLoReg;
	assign bSrcHi_next = wrBHi ? regWdata : bSrcHiReg;
	assign cEdge_next = wrCEdge ? {14'h0000, regWdata[1:0]} : cEdgeReg;
	assign cTrig_next = wrCTrig ? {15'h0000, regWdata[0]} : cTrigReg;
	assign cSrcLo_next = wrCLo ? regWdata : cSrcLoReg;
	assign cSrcHi_next = wrCHi ? regWdata : cSrcHiReg;

	// Reset leaves both units off, in single mode, on source zero.
	// Unit B configuration.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			bEdgeReg <= capture_pkg::ZERO16;
			bTrigReg <= capture_pkg::ZERO16;
			bSrcLoReg <= capture_pkg::SRC_RESET;
			bSrcHiReg <= capture_pkg::SRC_RESET;
		end else begin
			bEdgeReg <= bEdge_next;
			bTrigReg <= bTrig_next;
			bSrcLoReg <= bSrcLo_next;
			bSrcHiReg <= bSrcHi_next;
		end
	end

	// Unit C configuration.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			cEdgeReg <= capture_pkg::ZERO16;
			cTrigReg <= capture_pkg::ZERO16;
			cSrcLoReg <= capture_pkg::SRC_RESET;
			cSrcHiReg <= capture_pkg::SRC_RESET;
		end else begin
			cEdgeReg <= cEdge_next;
			cTrigReg <= cTrig_next;
			cSrcLoReg <= cSrcLo_next;
			cSrcHiReg <= cSrcHi_next;
		end
	end

	// The interrupt is built from the next status and next mask, so it rises in
	// the same cycle as the status bit and never lags a mask write by a cycle.
	assign mask_next = wrMask ? regWdata[1:0] : maskReg;
	assign irq_next = |(status_next & mask_next);

	// Read data is zero outside its answer cycle, so several such ports can be
	// merged by a plain OR without extra gating.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			statusReg <= capture_pkg::EVT_RESET;
			maskReg <= capture_pkg::EVT_RESET;
			rdataReg <= capture_pkg::ZERO16;
			irqReg <= 1'b0;
		end else begin
			statusReg <= status_next;
			maskReg <= mask_next;
			rdataReg <= rdata_next;
			irqReg <= irq_next;
		end
	end

	// Both outputs come straight from flip-flops; no logic follows them.
	assign regRdata = rdataReg;
	assign irq = irqReg;
endmodule

// ### logic/capture_pkg.sv
/*
 * Constants shared by the two-unit capture block: register indices, field
 * widths, edge and trigger codes, reset values.
 * Assumes a 16-bit plain register port with one-cycle read latency.
 */
package capture_pkg;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 4;
	localparam int SIG_W = 32;
	// Register indices on the plain register port.
	localparam logic [3:0] B_EDGE_ADDR = 4'h0;
	localparam logic [3:0] B_TRIG_ADDR = 4'h1;
	localparam logic [3:0] B_SRCLO_ADDR = 4'h2;
	localparam logic [3:0] B_SRCHI_ADDR = 4'h3;
	localparam logic [3:0] C_EDGE_ADDR = 4'h4;
	localparam logic [3:0] C_TRIG_ADDR = 4'h5;
	localparam logic [3:0] C_SRCLO_ADDR = 4'h6;
	localparam logic [3:0] C_SRCHI_ADDR = 4'h7;
	localparam logic [3:0] CTRL_ADDR = 4'h8;
	localparam logic [3:0] STATUS_ADDR = 4'h9;
	localparam logic [3:0] MASK_ADDR = 4'hA;
	localparam logic [3:0] B_VALLO_ADDR = 4'hB;
	localparam logic [3:0] B_VALHI_ADDR = 4'hC;
	localparam logic [3:0] C_VALLO_ADDR = 4'hD;
	localparam logic [3:0] C_VALHI_ADDR = 4'hE;
	// Edge selection codes.
	localparam logic [1:0] EDGE_OFF = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	localparam int EDGE_W = 2;
	// Trigger type codes.
	localparam logic TRIG_SINGLE = 1'b0;
	localparam logic TRIG_CONT = 1'b1;
	// Control and status bit positions (unit B in bit 0, unit C in bit 1).
	localparam int BIT_B = 0;
	localparam int BIT_C = 1;
	localparam int EVT_W = 2;
	localparam logic [15:0] ZERO16 = 16'h0000;
	localparam logic [15:0] SRC_RESET = 16'h0000;
	localparam logic [1:0] EVT_RESET = 2'h0;
endpackage

// ### logic/capture_unit.sv
/*
 * One capture unit: synchronises its trigger, detects the chosen edges and
 * latches the selected source in single or continuous mode.
 * Assumes the source value is already synchronous to mclk.
 */
`timescale 1ns/1ps
module capture_unit #(
	parameter int SIG_W = 32
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_b,
	// Configuration.
	input wire logic [1:0] edgeSel,
	input wire logic trigType,
	input wire logic rearm,
	// Trigger and data.
	input wire logic trigIn,
	input wire logic [SIG_W-1:0] srcVal,
	// Results.
	output logic [SIG_W-1:0] heldVal,
	output logic captured,
	output logic armed
);
	logic sync1Reg;
	logic sync2Reg;
	logic prevReg;
	logic [SIG_W-1:0] heldReg;
	logic capPulseReg;
	logic doneReg;
	logic rise;
	logic fall;
	logic qualify;
	logic fire;

	assign rise = sync2Reg & ~prevReg;
	assign fall = ~sync2Reg & prevReg;
	assign qualify = ((edgeSel == capture_pkg::EDGE_RISE) & rise) |
		((edgeSel == capture_pkg::EDGE_FALL) & fall) |
		((edgeSel == capture_pkg::EDGE_BOTH) & (rise | fall));
	// Single mode stays blocked once done; continuous never blocks.
	assign fire = qualify & ~(doneReg & (trigType == capture_pkg::TRIG_SINGLE));

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			sync1Reg <= 1'b0;
			sync2Reg <= 1'b0;
			prevReg <= 1'b0;
			heldReg <= '0;
			capPulseReg <= 1'b0;
			doneReg <= 1'b0;
		end else begin
			sync1Reg <= trigIn;
			sync2Reg <= sync1Reg;
			prevReg <= sync2Reg;
			capPulseReg <= fire;
			if (fire) begin
				heldReg <= srcVal;
			end
			if (fire) begin
				doneReg <= 1'b1;
			end else if (rearm) begin
				doneReg <= 1'b0;
			end
		end
	end

	assign heldVal = heldReg;
	assign captured = capPulseReg;
	assign armed = ~doneReg;
endmodule

// ### tb/capture_unit_b_c_config_props.sv
/*
 * Port-level assertions for the two-unit capture block.
 * Assumes one clock, mclk, and the synchronous active-low reset rst_b.
 */
`timescale 1ns/1ps
module capture_unit_b_c_config_props #(
	parameter int SIG_W = 32,
	parameter int NSRC = 128
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [3:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [15:0] regRdata,
	input wire logic trigB,
	input wire logic trigC,
	input wire logic [NSRC*SIG_W-1:0] srcBank,
	input wire logic irq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	a_rdata_idle_zero: assert property (!regRd |=> regRdata == 16'h0000)
		else $error("read data not zero outside a read answer");
	a_b_edge_readback: assert property (regWr && regAddr == capture_pkg::B_EDGE_ADDR ##2
		regRd && regAddr == capture_pkg::B_EDGE_ADDR |=> regRdata == {14'h0000, $past(regWdata[1:0], 3)})
		else $error("unit B edge readback wrong");
	a_c_edge_readback: assert property (regWr && regAddr == capture_pkg::C_EDGE_ADDR ##2
		regRd && regAddr == capture_pkg::C_EDGE_ADDR |=> regRdata == {14'h0000, $past(regWdata[1:0], 3)})
		else $error("unit C edge readback wrong");
	a_c_trig_readback: assert property (regWr && regAddr == capture_pkg::C_TRIG_ADDR ##2
		regRd && regAddr == capture_pkg::C_TRIG_ADDR |=> regRdata == {15'h0000, $past(regWdata[0], 3)})
		else $error("unit C trigger type readback wrong");
	a_src_lo_readback: assert property (regWr && regAddr == capture_pkg::B_SRCLO_ADDR ##2
		regRd && regAddr == capture_pkg::B_SRCLO_ADDR |=> regRdata == $past(regWdata, 3))
		else $error("unit B low source code readback wrong");
	a_unmapped_reads_zero: assert property (regRd && regAddr == 4'hF |=> regRdata == 16'h0000)
		else $error("unmapped read not zero");
	a_irq_edge_cause: assert property ($rose(irq) && !$past(regWr) |->
		$past(trigB, 4) != $past(trigB, 5) || $past(trigC, 4) != $past(trigC, 5))
		else $error("interrupt rose without a synchronised trigger edge");
	a_irq_fall_write: assert property ($fell(irq) |-> $past(regWr))
		else $error("interrupt fell without a register write");
endmodule
bind capture_unit_b_c_config capture_unit_b_c_config_props #(.SIG_W(SIG_W), .NSRC(NSRC))
	i_capture_unit_b_c_config_props (.mclk(mclk), .rst_b(rst_b), .regAddr(regAddr),
	.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .trigB(trigB),
	.trigC(trigC), .srcBank(srcBank), .irq(irq));

// ### tb/trig_driver.sv
/*
 * Far-side model of the two capture trigger inputs.
 * Assumes the caller waits for the task to return before the next level.
 */
`timescale 1ns/1ps
module trig_driver (
	input wire logic mclk,
	output logic trigB,
	output logic trigC
);
	initial begin
		trigB = 1'h0;
		trigC = 1'h0;
	end
	// Each level is held four clocks so the two-stage synchroniser always sees it.
	task automatic drive(input logic b, input logic c);
		@(posedge mclk);
		trigB <= b;
		trigC <= c;
		repeat (4) @(posedge mclk);
	endtask
endmodule

// ### tb/capture_unit_b_c_config_tb.sv
/*
 * Register-level testbench of the two-unit capture block.
 * Assumes the package register map and a 16-entry source bank.
 */
`timescale 1ns/1ps
module capture_unit_b_c_config_tb;
	logic mclk = 1'h0, rst_b = 1'h0, regWr = 1'h0, regRd = 1'h0, trigB, trigC, irq;
	logic [3:0] regAddr = 4'h0;
	logic [15:0] regWdata = 16'h0000, regRdata;
	logic [16*32-1:0] srcBank;
	int miscompares = 0, comparisons = 0, cycles = 0;
	always #50 mclk = ~mclk;
	capture_unit_b_c_config #(.SIG_W(32), .NSRC(16)) i_capture_unit_b_c_config (.mclk(mclk),
		.rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .trigB(trigB), .trigC(trigC), .srcBank(srcBank), .irq(irq));
	trig_driver i_trig_driver (.mclk(mclk), .trigB(trigB), .trigC(trigC));
	function automatic logic [31:0] word(input logic [15:0] k);
		return {16'hA000 | k, 16'h5000 | k};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'h1;
		@(posedge mclk);
		regWr <= 1'h0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge mclk);
		regAddr <= a;
		regRd <= 1'h1;
		@(posedge mclk);
		regRd <= 1'h0;
		#1 check({16'h0000, regRdata}, {16'h0000, exp});
	endtask
	// The captured word is read as its low half, then its high half.
	task automatic rd_val(input logic [3:0] a, input logic [31:0] exp);
		rd(a, exp[15:0]);
		rd(a + 4'h1, exp[31:16]);
	endtask
	task automatic end_of_test;
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			end_of_test;
		end
	end
	initial begin
		for (int k = 0; k < 16; k++)
			srcBank[k*32 +: 32] = word(16'(k));
		repeat (3) @(posedge mclk);
		rst_b <= 1'h1;
		for (int i = 0; i < 8; i++)
			rd(4'(i), 16'h0000);
		rd(capture_pkg::CTRL_ADDR, 16'h0003);
		for (int i = 0; i < 8; i++) begin
			wr(4'(i), 16'hFFFF);
			rd(4'(i), (i % 4 == 0) ? 16'h0003 : (i % 4 == 1) ? 16'h0001 : 16'hFFFF);
		end
		wr(4'hF, 16'hFFFF);
		rd(4'hF, 16'h0000);
		wr(capture_pkg::B_SRCLO_ADDR, 16'h0003);
		wr(capture_pkg::B_SRCHI_ADDR, 16'h0005);
		for (int code = 0; code < 4; code++) begin
			wr(capture_pkg::B_EDGE_ADDR, 16'(code));
			wr(capture_pkg::STATUS_ADDR, 16'h0003);
			i_trig_driver.drive(1'h1, 1'h0);
			rd(capture_pkg::STATUS_ADDR, {15'h0000, 1'(code)});
			wr(capture_pkg::STATUS_ADDR, 16'h0003);
			i_trig_driver.drive(1'h0, 1'h0);
			rd(capture_pkg::STATUS_ADDR, {15'h0000, 1'(code >> 1)});
		end
		rd_val(capture_pkg::B_VALLO_ADDR, {16'hA005, 16'h5003});
		wr(capture_pkg::B_SRCLO_ADDR, 16'h0007);
		i_trig_driver.drive(1'h1, 1'h0);
		rd_val(capture_pkg::B_VALLO_ADDR, {16'hA005, 16'h5007});
		#1 check({31'h0, irq}, 32'h0);
		wr(capture_pkg::MASK_ADDR, 16'h0003);
		#1 check({31'h0, irq}, 32'h1);
		wr(capture_pkg::STATUS_ADDR, 16'h0001);
		#1 check({31'h0, irq}, 32'h0);
		wr(capture_pkg::C_EDGE_ADDR, 16'h0001);
		wr(capture_pkg::C_TRIG_ADDR, 16'h0000);
		wr(capture_pkg::C_SRCLO_ADDR, 16'h0002);
		wr(capture_pkg::C_SRCHI_ADDR, 16'h0002);
		i_trig_driver.drive(1'h1, 1'h1);
		#1 check({31'h0, irq}, 32'h1);
		i_trig_driver.drive(1'h1, 1'h0);
		rd_val(capture_pkg::C_VALLO_ADDR, word(16'h0002));
		wr(capture_pkg::C_SRCLO_ADDR, 16'h0004);
		i_trig_driver.drive(1'h1, 1'h1);
		i_trig_driver.drive(1'h1, 1'h0);
		rd_val(capture_pkg::C_VALLO_ADDR, word(16'h0002));
		rd(capture_pkg::CTRL_ADDR, 16'h0000);
		wr(capture_pkg::CTRL_ADDR, 16'h0002);
		rd(capture_pkg::CTRL_ADDR, 16'h0002);
		i_trig_driver.drive(1'h1, 1'h1);
		rd_val(capture_pkg::C_VALLO_ADDR, {16'hA002, 16'h5004});
		end_of_test;
	end
endmodule
